// [src/ctm_pkg.sv]
// constants and register layout for the cascaded 32-bit timer
package ctm_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_LOW_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HIGH_CTRL = 8'h04;
  localparam logic [7:0] ADDR_LOW_COUNT = 8'h08;
  localparam logic [7:0] ADDR_HIGH_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h10;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h14;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
  // control register fields
  localparam int TIMER_ON_BIT = 15;
  localparam int GATE_EN_BIT = 6;
  localparam int PRESC_HI_BIT = 5;
  localparam int PRESC_LO_BIT = 4;
  localparam int CLK_SRC_BIT = 1;
  // interrupt flag / enable position
  localparam int PERIOD_IRQ_BIT = 7;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  // prescale select codes and their terminal counts
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV8 = 2'h1;
  localparam logic [1:0] PRESC_DIV64 = 2'h2;
  localparam logic [1:0] PRESC_DIV256 = 2'h3;
  localparam logic [7:0] PRESC_TC1 = 8'h00;
  localparam logic [7:0] PRESC_TC8 = 8'h07;
  localparam logic [7:0] PRESC_TC64 = 8'h3F;
  localparam logic [7:0] PRESC_TC256 = 8'hFF;
  // ahb constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : ctm_pkg

// [src/ctm_prescaler.sv]
// prescaler counter with selectable divide ratio and clear input
`timescale 1ns/1ps
module ctm_prescaler (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic tick_in, // input clock enable
  input wire logic clear, // clear the prescale counter
  input wire logic [1:0] select, // divide ratio code
  output logic tick_out // prescaled enable pulse
);
  typedef struct packed {
    logic [7:0] cnt;
  } ctm_psc_state_t;

  ctm_psc_state_t st_r;
  ctm_psc_state_t st_nxt;
  logic [7:0] term;

  // terminal count of the selected ratio
  always_comb begin
    case (select)
      ctm_pkg::PRESC_DIV1: term = ctm_pkg::PRESC_TC1;
      ctm_pkg::PRESC_DIV8: term = ctm_pkg::PRESC_TC8;
      ctm_pkg::PRESC_DIV64: term = ctm_pkg::PRESC_TC64;
      default: term = ctm_pkg::PRESC_TC256;
    endcase
  end

  // output pulse fires on the input tick taken while the count already sits at the terminal count
  assign tick_out = tick_in && !clear && (st_r.cnt >= term);

  // clear only takes effect while clocked by the system clock
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.cnt = 8'h00;
    end else if (tick_in) begin
      st_nxt.cnt = (st_r.cnt >= term) ? 8'h00 : st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ctm_prescaler

// [src/ctm_edge_detect.sv]
// rising and falling edge detector for the gate input
`timescale 1ns/1ps
module ctm_edge_detect (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic sig_in, // synchronous input level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic prev;
  } ctm_edge_state_t;

  ctm_edge_state_t st_r;
  ctm_edge_state_t st_nxt;

  // compare current level against the last sampled one
  always_comb begin
    st_nxt.prev = sig_in;
  end

  assign rise = sig_in && !st_r.prev;
  assign fall = !sig_in && st_r.prev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ctm_edge_detect

// [src/ctm_timer32.sv]
// cascaded 32-bit timer with ahb-lite register slave
//
// Contract
// RULE1: gated mode counts instruction clocks while gate high
// RULE2: lower timer sources clock; upper gate bit ignored
// RULE3: software enables timer, internal source before gating
// RULE4: gate falling edge stops counting, count kept
// RULE5: adc trigger pulse on 32-bit period match
// RULE6: prescaler divides by 1, 8, 64, 256
// RULE7: only lower prescale field used
// RULE8: prescaler cleared by count write or timer off
// RULE9: disabled timer prescaler is not resettable
// RULE10: control writes leave count untouched
// RULE11: no counting during sleep
// RULE12: flag set on period match or gate fall
// RULE13: interrupt only when flag and enable set
// RULE14: software clears flag, hardware never does
// RULE15: upper half msb, lower half lsb, one step
// RULE16: after match count restarts from zero
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module ctm_timer32 (
  input wire logic clk, // 25 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write strobe
  input wire logic [2:0] hsize, // ahb transfer size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  input wire logic gate_input_pin, // gate or external clock input
  input wire logic sleep, // cpu sleep, stops counting
  output logic adc_trigger, // one-cycle adc trigger event
  output logic irq // level interrupt request
);
  typedef struct packed {
    logic [15:0] low_ctrl;
    logic [15:0] high_ctrl;
    logic [15:0] low_count;
    logic [15:0] high_count;
    logic [15:0] period_low;
    logic [15:0] period_high;
    logic [15:0] irq_flag;
    logic [15:0] irq_enable;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic trig;
    logic match_pend;
  } ctm_state_t;

  ctm_state_t st_r;
  ctm_state_t st_nxt;

  logic gate_rise;
  logic gate_fall;
  logic presc_clear;
  logic base_tick;
  logic presc_tick;
  logic timer_on;
  logic gated;
  logic ext_src;
  logic addr_phase;
  logic [31:0] count32;
  logic [31:0] period32;
  logic match;

  // *************************************************************
  // register read decode
  // *************************************************************
  function automatic logic [31:0] read_reg(input ctm_state_t s, input logic [7:0] a);
    case (a)
      ctm_pkg::ADDR_LOW_CTRL: read_reg = {16'h0000, s.low_ctrl};
      ctm_pkg::ADDR_HIGH_CTRL: read_reg = {16'h0000, s.high_ctrl};
      ctm_pkg::ADDR_LOW_COUNT: read_reg = {16'h0000, s.low_count};
      ctm_pkg::ADDR_HIGH_COUNT: read_reg = {16'h0000, s.high_count};
      ctm_pkg::ADDR_PERIOD_LOW: read_reg = {16'h0000, s.period_low};
      ctm_pkg::ADDR_PERIOD_HIGH: read_reg = {16'h0000, s.period_high};
      ctm_pkg::ADDR_IRQ_FLAG: read_reg = {16'h0000, s.irq_flag};
      ctm_pkg::ADDR_IRQ_ENABLE: read_reg = {16'h0000, s.irq_enable};
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  // *************************************************************
  // clock source, gating and prescaler
  // *************************************************************
  // the lower timer's source, gate and prescale bits rule in 32-bit mode; the on bits of both halves must be set
  assign timer_on = st_r.low_ctrl[ctm_pkg::TIMER_ON_BIT] &&
                    st_r.high_ctrl[ctm_pkg::TIMER_ON_BIT]; // RULE2
  assign ext_src = st_r.low_ctrl[ctm_pkg::CLK_SRC_BIT]; // RULE2
  assign gated = st_r.low_ctrl[ctm_pkg::GATE_EN_BIT] && !ext_src; // RULE1 RULE2 RULE3

  ctm_edge_detect u_gate_edge (
    .clk(clk),
    .rstn(rstn),
    .sig_in(gate_input_pin),
    .rise(gate_rise),
    .fall(gate_fall)
  );

  // internal source ticks every cycle; gated mode only while the pin is high
  always_comb begin
    if (!timer_on || sleep) begin
      base_tick = 1'b0; // RULE11
    end else if (ext_src) begin
      base_tick = gate_rise;
    end else if (gated) begin
      base_tick = gate_input_pin; // RULE1 RULE4
    end else begin
      base_tick = 1'b1;
    end
  end

  // a disabled timer has no prescaler clock, so clears need it running;
  // switching either half off clears it in the same step as it stops
  assign presc_clear = timer_on && st_r.wr_pend &&
                       (st_r.wr_addr == ctm_pkg::ADDR_LOW_COUNT ||
                        st_r.wr_addr == ctm_pkg::ADDR_HIGH_COUNT ||
                        ((st_r.wr_addr == ctm_pkg::ADDR_LOW_CTRL ||
                          st_r.wr_addr == ctm_pkg::ADDR_HIGH_CTRL) &&
                         !hwdata[ctm_pkg::TIMER_ON_BIT])); // RULE8 RULE9

  ctm_prescaler u_presc (
    .clk(clk),
    .rstn(rstn),
    .tick_in(base_tick),
    .clear(presc_clear),
    .select(st_r.low_ctrl[ctm_pkg::PRESC_HI_BIT:ctm_pkg::PRESC_LO_BIT]), // RULE6 RULE7
    .tick_out(presc_tick)
  );

  assign count32 = {st_r.high_count, st_r.low_count}; // RULE15
  assign period32 = {st_r.period_high, st_r.period_low};
  assign match = timer_on && (count32 == period32);

  // *************************************************************
  // bus slave
  // *************************************************************
  // zero wait states; every transfer answers okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign adc_trigger = st_r.trig;
  assign irq = |(st_r.irq_flag & st_r.irq_enable); // RULE13
  assign addr_phase = hsel && hready && (htrans == ctm_pkg::HTRANS_NONSEQ);

  // *************************************************************
  // next state
  // *************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    st_nxt.trig = 1'b0;
    // counting: the prescaled step taken while on the period restarts at zero
    if (presc_tick) begin
      if (match) begin
        st_nxt.low_count = ctm_pkg::COUNT_RESET; // RULE16
        st_nxt.high_count = ctm_pkg::COUNT_RESET; // RULE16
      end else begin
        {st_nxt.high_count, st_nxt.low_count} = count32 + 32'h0000_0001; // RULE15
      end
    end
    // match is reported once, when the count first lands on it; a slow
    // prescale ratio keeps the count on the period for many cycles
    st_nxt.match_pend = match;
    if (match && !st_r.match_pend) begin
      st_nxt.trig = 1'b1; // RULE5
    end
    if (!timer_on) begin
      st_nxt.match_pend = 1'b0;
    end
    // write data phase; control writes do not touch the count
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        ctm_pkg::ADDR_LOW_CTRL: st_nxt.low_ctrl = hwdata[15:0]; // RULE10
        ctm_pkg::ADDR_HIGH_CTRL: st_nxt.high_ctrl = hwdata[15:0]; // RULE10
        ctm_pkg::ADDR_LOW_COUNT: begin
          st_nxt.low_count = hwdata[15:0];
          st_nxt.match_pend = 1'b0;
        end
        ctm_pkg::ADDR_HIGH_COUNT: begin
          st_nxt.high_count = hwdata[15:0];
          st_nxt.match_pend = 1'b0;
        end
        ctm_pkg::ADDR_PERIOD_LOW: st_nxt.period_low = hwdata[15:0];
        ctm_pkg::ADDR_PERIOD_HIGH: st_nxt.period_high = hwdata[15:0];
        ctm_pkg::ADDR_IRQ_FLAG: st_nxt.irq_flag = st_r.irq_flag & ~hwdata[15:0]; // RULE14
        ctm_pkg::ADDR_IRQ_ENABLE: st_nxt.irq_enable = hwdata[15:0];
        default: st_nxt.irq_enable = st_r.irq_enable;
      endcase
    end
    // hardware sets after the clear so a coincident event wins
    if ((match && !st_r.match_pend) || (gated && timer_on && gate_fall)) begin
      st_nxt.irq_flag[ctm_pkg::PERIOD_IRQ_BIT] = 1'b1; // RULE12
    end
    // address phase capture and read data
    if (addr_phase) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = {haddr[7:2], 2'b00};
      st_nxt.rdata = hwrite ? 32'h0000_0000 : read_reg(st_r, {haddr[7:2], 2'b00});
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.period_low <= ctm_pkg::PERIOD_RESET;
      st_r.period_high <= ctm_pkg::PERIOD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ctm_timer32

// [test/ctm_gate_src.sv]
// gate pulse source standing in for the outside signal
`timescale 1ns/1ps
module ctm_gate_src (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic go, // start pulse
  input wire logic [7:0] len, // pulse cycles
  output logic gate // gate level
);
  logic [7:0] left_r;
  // gate stays high exactly len cycles, low between pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) left_r <= 8'h00;
    else if (go) left_r <= len;
    else if (left_r != 8'h00) left_r <= left_r - 8'h01;
  end
  assign gate = left_r != 8'h00;
endmodule : ctm_gate_src

// [test/ctm_timer32_chk.sv]
// port checker for the cascaded 32-bit timer
`timescale 1ns/1ps
module ctm_timer32_chk (
  input wire logic clk, // clk
  input wire logic rstn, // rst
  input wire logic hsel, // sel
  input wire logic [31:0] haddr, // addr
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // dir
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // wdata
  input wire logic hready, // rdy
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // srdy
  input wire logic hresp, // resp
  input wire logic gate_input_pin, // gate
  input wire logic sleep, // sleep
  input wire logic adc_trigger, // trig
  input wire logic irq // irq
);
  logic ap;
  logic wr_r;
  logic [7:0] wa_r;
  assign ap = hsel && hready && htrans == ctm_pkg::HTRANS_NONSEQ;
  // remember the last write so an irq drop can be traced to software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
    end else begin
      wr_r <= ap && hwrite;
      wa_r <= haddr[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  AST_HALF: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_HOLD: assert property (!ap |=> $stable(hrdata))
    else $error("read data moved");
  AST_UNMAP: assert property (ap && !hwrite && haddr[7:0] > 8'h1C |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RST: assert property (disable iff (1'b0) !rstn |-> !adc_trigger && !irq)
    else $error("outputs active in reset");
  AST_PULSE: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger longer than one cycle");
  AST_STICKY: assert property ($fell(irq) |-> $past(wr_r) &&
    ($past(wa_r) == ctm_pkg::ADDR_IRQ_FLAG || $past(wa_r) == ctm_pkg::ADDR_IRQ_ENABLE))
    else $error("irq dropped without a write");
  AST_SLEEP: assert property (sleep [*4] |-> !adc_trigger)
    else $error("trigger during sleep");
  cover property (adc_trigger);
  cover property ($fell(irq));
  cover property (ap && !hwrite && haddr[7:0] > 8'h1C);
endmodule : ctm_timer32_chk
bind ctm_timer32 ctm_timer32_chk u_chk (.*);

// [test/cascaded_32bit_timer_tb.sv]
// self-checking bench for the cascaded 32-bit timer
`timescale 1ns/1ps
module cascaded_32bit_timer_tb;
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic gate_input_pin, sleep, adc_trigger, irq, g_go;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, p;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] g_len;
  int failures, total_checks, n;
  assign hready = hreadyout;
  ctm_timer32 DUT (.*);
  ctm_gate_src u_gate (.clk(clk), .rstn(rstn), .go(g_go), .len(g_len), .gate(gate_input_pin));
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // cycles between matches for a prescale code and period
  function automatic int span(input logic [1:0] c, input logic [31:0] q);
    return (c == 2'h0 ? 1 : c == 2'h1 ? 8 : c == 2'h2 ? 64 : 256) * int'(q + 32'h1);
  endfunction : span
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // single transfer; data phase held until hready, read data lands in rd
  task automatic bx(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= ctm_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bx
  task automatic wt(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (adc_trigger !== 1'b1 && n < lim);
  endtask : wt
  // stop first, so a count above the new period cannot run away
  task automatic cfg(input logic [31:0] lo, hi, per, cnt);
    bx(1'b1, ctm_pkg::ADDR_LOW_CTRL, 32'h0);
    bx(1'b1, ctm_pkg::ADDR_LOW_COUNT, {16'h0, cnt[15:0]});
    bx(1'b1, ctm_pkg::ADDR_HIGH_COUNT, {16'h0, cnt[31:16]});
    bx(1'b1, ctm_pkg::ADDR_PERIOD_LOW, {16'h0, per[15:0]});
    bx(1'b1, ctm_pkg::ADDR_PERIOD_HIGH, {16'h0, per[31:16]});
    bx(1'b1, ctm_pkg::ADDR_HIGH_CTRL, hi);
    bx(1'b1, ctm_pkg::ADDR_LOW_CTRL, lo);
  endtask : cfg
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    {hsel, hwrite, sleep, g_go, rstn, htrans, g_len} = 15'h0000;
    {haddr, hwdata} = 64'h0;
    hsize = ctm_pkg::HSIZE_WORD;
    seed = 32'h00005869;
    failures = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values, then one address past the map
    for (int a = 0; a < 9; a++) begin
      bx(1'b0, 8'(a * 4), 32'h0);
      chk(rd, (a == 4 || a == 5) ? 32'h0000FFFF : 32'h0);
    end
    bx(1'b1, ctm_pkg::ADDR_IRQ_ENABLE, 32'h80);
    // every prescale code; upper control carries a conflicting code and gate bit
    for (int c = 0; c < 4; c++) begin
      seed = xs(seed);
      p = {28'h0, seed[3:0]} + 32'h8;
      cfg({16'h0, 1'b1, 9'h0, 2'(c), 4'h0},
          {16'h0, 1'b1, 8'h0, 1'b1, 2'(~c), 4'h0}, p, 32'h0);
      wt(9000);
      wt(9000);
      chk(n, span(2'(c), p));
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bx(1'b1, ctm_pkg::ADDR_IRQ_FLAG, 32'h80);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    // masked match, then a sleep stretch that must freeze the count
    bx(1'b1, ctm_pkg::ADDR_IRQ_ENABLE, 32'h0);
    cfg(32'h8000, 32'h8000, p, 32'h0);
    wt(9000);
    sleep <= 1'b1;
    repeat (50) @(posedge clk);
    sleep <= 1'b0;
    wt(9000);
    chk(n, span(2'h0, p));
    chk({31'h0, irq}, 32'h0);
    bx(1'b1, ctm_pkg::ADDR_IRQ_ENABLE, 32'h80);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    // a count write mid-run restarts the divide by 8 from its first cycle
    cfg(32'h8010, 32'h8000, p, 32'h0);
    wt(9000);
    bx(1'b1, ctm_pkg::ADDR_LOW_COUNT, 32'h3);
    wt(9000);
    chk(n, 32'h8 * (p - 32'h3) + 32'h2);
    // carry from the lower into the upper half
    cfg(32'h0, 32'h8000, 32'h00010001, 32'h0000FFFE);
    bx(1'b1, ctm_pkg::ADDR_LOW_CTRL, 32'h0070);
    bx(1'b0, ctm_pkg::ADDR_LOW_COUNT, 32'h0);
    chk(rd, 32'h0000FFFE);
    bx(1'b1, ctm_pkg::ADDR_LOW_CTRL, 32'h8000);
    wt(20);
    chk({31'h0, adc_trigger}, 32'h1);
    // gated accumulation over a random pulse from the gate source
    cfg(32'h0, 32'h8000, 32'hFFFFFFFF, 32'h0);
    bx(1'b1, ctm_pkg::ADDR_IRQ_FLAG, 32'h80);
    bx(1'b1, ctm_pkg::ADDR_LOW_CTRL, 32'h8040);
    seed = xs(seed);
    g_len <= 8'h05 + {3'h0, seed[4:0]};
    g_go <= 1'b1;
    @(posedge clk);
    g_go <= 1'b0;
    repeat (45) @(posedge clk);
    bx(1'b0, ctm_pkg::ADDR_LOW_COUNT, 32'h0);
    chk(rd, {24'h0, g_len});
    bx(1'b0, ctm_pkg::ADDR_IRQ_FLAG, 32'h0);
    chk(rd, 32'h80);
    repeat (9) @(posedge clk);
    bx(1'b0, ctm_pkg::ADDR_LOW_COUNT, 32'h0);
    chk(rd, {24'h0, g_len});
    // external source: one step per rising edge of the pin
    cfg(32'h8002, 32'h8000, 32'hFFFFFFFF, 32'h0);
    g_len <= 8'h03;
    repeat (2) begin
      g_go <= 1'b1;
      @(posedge clk);
      g_go <= 1'b0;
      repeat (9) @(posedge clk);
    end
    bx(1'b0, ctm_pkg::ADDR_LOW_COUNT, 32'h0);
    chk(rd, 32'h2);
    conclude();
  end
  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    failures++;
    conclude();
  end
endmodule : cascaded_32bit_timer_tb
